// ### logic/trim_pkg.sv
// constants, register map and state codes for the bus timing trim block
package trim_pkg;
  // =====================================================
  // register map
  localparam logic [11:0] TRIM_CFG_ADDR = 12'h4fc;
  localparam logic [11:0] TRIM_STATUS_ADDR = 12'h4f8;
  localparam int CFG_WIDTH = 6;
  localparam logic [CFG_WIDTH-1:0] CFG_RESET = 6'h00;
  localparam int ACK_FLT_BIT = 0;
  localparam int STRB_REC_BIT = 1;
  localparam int RD_TERM_LSB = 2;
  localparam int RD_TERM_MSB = 3;
  localparam int POSTED_BIT = 4;
  localparam int PREFETCH_BIT = 5;
  localparam logic [1:0] RT_FULL = 2'h0;
  localparam logic [1:0] RT_SHORT = 2'h1;
  localparam logic [1:0] RT_NONE = 2'h2;
  // =====================================================
  // timing, clock period 20 ns
  localparam int CLK_NS = 20;
  localparam int T11_NS = 40;
  localparam int T11_TRIM_NS = 20;
  localparam int T27_NS = 25;
  localparam int T27_SHORT_NS = 20;
  localparam int T28_NS = 30;
  localparam int T28_TRIM_NS = 20;
  localparam logic [2:0] T11_CYC = 3'((T11_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] T11_TRIM_CYC = 3'((T11_TRIM_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] T27_CYC = 3'((T27_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] T27_SHORT_CYC = 3'((T27_SHORT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] T28_CYC = 3'((T28_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] T28_TRIM_CYC = 3'((T28_TRIM_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] CNT_MAX = 3'h7;
  localparam int ACK_FULL_SAMPLES = 4;
  localparam int ACK_REDUCED_SAMPLES = 2;
  // =====================================================
  // master sequencer states
  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_RECOVER = 3'h1,
    M_STROBE = 3'h3,
    M_HOLD = 3'h2,
    M_DONE = 3'h6
  } mst_state_e;
endpackage

// ### logic/pin_qualifier.sv
// three-flop synchroniser followed by a consecutive-sample glitch filter
`timescale 1ns/1ps
module pin_qualifier
  import trim_pkg::*;
#(
  parameter int MAX_SAMPLES = ACK_FULL_SAMPLES,
  parameter int MIN_SAMPLES = ACK_REDUCED_SAMPLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  input wire logic reduce_in,
  output logic level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic [2:0] cnt_reg;
  logic [2:0] need;
  logic differs;
  logic flip;

  // s1 feeds s2 only; the filter looks at s2 and s3
  assign need = reduce_in ? 3'(MIN_SAMPLES) : 3'(MAX_SAMPLES);
  assign differs = (s2_reg == s3_reg) && (s3_reg != level_out);
  // compare with >= so a smaller need set mid-count cannot let the counter wrap
  assign flip = differs && (cnt_reg >= need - 3'h1);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      cnt_reg <= 3'h0;
      level_out <= 1'b1;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      cnt_reg <= (differs && !flip) ? cnt_reg + 3'h1 : 3'h0;
      if (flip) begin
        level_out <= s3_reg;
      end
    end
  end
endmodule

// ### logic/vme_timing_trim_control.sv
// bus master and slave strobe timing with software trims, apb config port
// =====================================================
// Notes on behaviour
// - acknowledge input needs four agreeing samples
// - reduced filter setting needs fewer samples
// - default: DS0 waits 40 ns both-strobes-high
// - recovery trim lets DS0 fall sooner
// - default read: latch/end 25 ns after acknowledge
// - read trim: shorter delay, or none
// - default slave: acknowledge 30 ns after strobe
// - posted-write trim allows earlier acknowledge
// - prefetch-read trim allows earlier acknowledge
// - all trims in one register at 0x4fc
`timescale 1ns/1ps
module vme_timing_trim_control
  import trim_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic DTACK_N_IN,
  input wire logic DS0_N_IN,
  input wire logic DS1_N_IN,
  input wire logic MST_REQ_IN,
  input wire logic MST_READ_IN,
  output logic DS0_N_OUT,
  output logic MST_TERMINATE_OUT,
  input wire logic SLV_ACK_REQ_IN,
  input wire logic SLV_POSTED_WR_IN,
  input wire logic SLV_PREFETCH_RD_IN,
  output logic SLV_DTACK_OE_N_OUT
);
  logic [CFG_WIDTH-1:0] timing_trim_config_reg;
  mst_state_e mst_state_reg;
  mst_state_e mst_state_next;
  logic [2:0] both_high_cnt_reg;
  logic [2:0] hold_cnt_reg;
  logic [2:0] hold_cnt_next;
  logic [2:0] slv_cnt_reg;
  logic term_next;
  logic dtack_q;
  logic ds0_q;
  logic ds1_q;

  // =====================================================
  // config fields
  wire ack_inactive_filter_sel = timing_trim_config_reg[ACK_FLT_BIT];
  wire master_strobe_recovery_trim = timing_trim_config_reg[STRB_REC_BIT];
  wire [1:0] master_read_term_trim = timing_trim_config_reg[RD_TERM_MSB:RD_TERM_LSB];
  wire slave_posted_write_ack_trim = timing_trim_config_reg[POSTED_BIT];
  wire slave_prefetch_read_ack_trim = timing_trim_config_reg[PREFETCH_BIT];

  // =====================================================
  // pin qualification
  pin_qualifier #(.MAX_SAMPLES(ACK_FULL_SAMPLES), .MIN_SAMPLES(ACK_REDUCED_SAMPLES)) u_dtack (
    .clk_in(CLOCK_IN),
    .rst_in(RST_IN),
    .pin_in(DTACK_N_IN),
    .reduce_in(ack_inactive_filter_sel),
    .level_out(dtack_q)
  );
  // strobes only need the synchroniser plus a short agreement
  pin_qualifier #(.MAX_SAMPLES(ACK_REDUCED_SAMPLES), .MIN_SAMPLES(ACK_REDUCED_SAMPLES)) u_ds0 (
    .clk_in(CLOCK_IN),
    .rst_in(RST_IN),
    .pin_in(DS0_N_IN),
    .reduce_in(1'b1),
    .level_out(ds0_q)
  );
  pin_qualifier #(.MAX_SAMPLES(ACK_REDUCED_SAMPLES), .MIN_SAMPLES(ACK_REDUCED_SAMPLES)) u_ds1 (
    .clk_in(CLOCK_IN),
    .rst_in(RST_IN),
    .pin_in(DS1_N_IN),
    .reduce_in(1'b1),
    .level_out(ds1_q)
  );

  // =====================================================
  // apb slave
  wire apb_setup = PSEL_IN & ~PENABLE_IN;
  wire apb_access = PSEL_IN & PENABLE_IN & PREADY_OUT;
  wire hit_cfg = (PADDR_IN == TRIM_CFG_ADDR);
  wire hit_status = (PADDR_IN == TRIM_STATUS_ADDR);
  wire cfg_write = apb_access & PWRITE_IN & hit_cfg;
  wire [31:0] status_word = {25'h0, mst_state_reg, SLV_DTACK_OE_N_OUT, ds1_q, ds0_q, dtack_q};
  wire [31:0] rd_mux = hit_cfg ? 32'(timing_trim_config_reg) : hit_status ? status_word : 32'h0;

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      timing_trim_config_reg <= CFG_RESET;
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0;
    end else begin
      PREADY_OUT <= apb_setup;
      PSLVERR_OUT <= apb_setup & ~(hit_cfg | hit_status);
      PRDATA_OUT <= apb_setup ? rd_mux : 32'h0;
      if (cfg_write) begin
        timing_trim_config_reg <= PWDATA_IN[CFG_WIDTH-1:0];
      end
    end
  end

  // =====================================================
  // master side
  wire both_high = ds0_q & ds1_q;
  wire [2:0] recover_need = master_strobe_recovery_trim ? T11_TRIM_CYC : T11_CYC;
  wire recovered = both_high && (both_high_cnt_reg >= recover_need);
  // reserved code 3 falls back to the full delay
  wire [2:0] term_need = (master_read_term_trim == RT_NONE) ? 3'h0 :
                         (master_read_term_trim == RT_SHORT) ? T27_SHORT_CYC : T27_CYC;
  wire ack_seen = ~dtack_q;

  always_comb begin
    mst_state_next = mst_state_reg;
    hold_cnt_next = 3'h0;
    term_next = 1'b0;
    unique case (mst_state_reg)
      M_IDLE: begin
        if (MST_REQ_IN) begin
          mst_state_next = M_RECOVER;
        end
      end
      M_RECOVER: begin
        if (!MST_REQ_IN) begin
          mst_state_next = M_IDLE;
        end else if (recovered) begin
          mst_state_next = M_STROBE;
        end
      end
      M_STROBE: begin
        if (!MST_REQ_IN) begin
          mst_state_next = M_DONE;
        end else if (ack_seen) begin
          if (MST_READ_IN && term_need != 3'h0) begin
            mst_state_next = M_HOLD;
            hold_cnt_next = 3'h1;
          end else begin
            mst_state_next = M_DONE;
            term_next = 1'b1;
          end
        end
      end
      M_HOLD: begin
        if (hold_cnt_reg >= term_need) begin
          mst_state_next = M_DONE;
          term_next = 1'b1;
        end else begin
          hold_cnt_next = hold_cnt_reg + 3'h1;
        end
      end
      M_DONE: begin
        if (!MST_REQ_IN) begin
          mst_state_next = M_IDLE;
        end
      end
      default: begin
        mst_state_next = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      mst_state_reg <= M_IDLE;
      hold_cnt_reg <= 3'h0;
      both_high_cnt_reg <= 3'h0;
      DS0_N_OUT <= 1'b1;
      MST_TERMINATE_OUT <= 1'b0;
    end else begin
      mst_state_reg <= mst_state_next;
      hold_cnt_reg <= hold_cnt_next;
      MST_TERMINATE_OUT <= term_next;
      DS0_N_OUT <= !(mst_state_next == M_STROBE || mst_state_next == M_HOLD);
      // saturating: only the threshold matters, not the full idle time
      if (!both_high) begin
        both_high_cnt_reg <= 3'h0;
      end else if (both_high_cnt_reg != CNT_MAX) begin
        both_high_cnt_reg <= both_high_cnt_reg + 3'h1;
      end
    end
  end

  // =====================================================
  // slave side
  wire ds_active = ~ds0_q | ~ds1_q;
  wire trimmed_ack = (SLV_POSTED_WR_IN & slave_posted_write_ack_trim) |
                     (SLV_PREFETCH_RD_IN & slave_prefetch_read_ack_trim);
  wire [2:0] ack_need = trimmed_ack ? T28_TRIM_CYC : T28_CYC;
  wire ack_ok = ds_active && SLV_ACK_REQ_IN && (slv_cnt_reg >= ack_need);

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      slv_cnt_reg <= 3'h0;
      SLV_DTACK_OE_N_OUT <= 1'b1;
    end else begin
      SLV_DTACK_OE_N_OUT <= !ack_ok;
      if (!ds_active) begin
        slv_cnt_reg <= 3'h0;
      end else if (slv_cnt_reg != CNT_MAX) begin
        slv_cnt_reg <= slv_cnt_reg + 3'h1;
      end
    end
  end

  // =====================================================
  // checks
  property p_ack_full;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      ($fell(dtack_q) && !ack_inactive_filter_sel) |->
        ($past(DTACK_N_IN, 3) == 1'b0 && $past(DTACK_N_IN, 7) == 1'b0);
  endproperty
  a_ack_full: assert property (p_ack_full) else $error("ack accepted too early");
  property p_ack_reduced;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (ack_inactive_filter_sel && !DTACK_N_IN)[*5] |=> !dtack_q;
  endproperty
  a_ack_reduced: assert property (p_ack_reduced) else $error("reduced filter slow");
  property p_recover_full;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      ($fell(DS0_N_OUT) && !$past(master_strobe_recovery_trim)) |->
        $past(both_high_cnt_reg) >= T11_CYC;
  endproperty
  a_recover_full: assert property (p_recover_full) else $error("DS0 recovery short");
  property p_recover_trim;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (mst_state_reg == M_RECOVER && MST_REQ_IN && master_strobe_recovery_trim &&
       both_high && both_high_cnt_reg >= T11_TRIM_CYC) |=> !DS0_N_OUT;
  endproperty
  a_recover_trim: assert property (p_recover_trim) else $error("trimmed DS0 late");
  property p_read_full;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (MST_TERMINATE_OUT && MST_READ_IN && master_read_term_trim == RT_FULL) |->
        $past(hold_cnt_reg) >= T27_CYC;
  endproperty
  a_read_full: assert property (p_read_full) else $error("read ended too soon");
  property p_read_none;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (mst_state_reg == M_STROBE && MST_REQ_IN && ack_seen && MST_READ_IN &&
       master_read_term_trim == RT_NONE) |=> (MST_TERMINATE_OUT && DS0_N_OUT);
  endproperty
  a_read_none: assert property (p_read_none) else $error("no-delay read late");
  property p_slave_full;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      ($fell(SLV_DTACK_OE_N_OUT) && !$past(trimmed_ack)) |-> $past(slv_cnt_reg) >= T28_CYC;
  endproperty
  a_slave_full: assert property (p_slave_full) else $error("slave ack too early");
  property p_slave_posted;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (ds_active && SLV_ACK_REQ_IN && SLV_POSTED_WR_IN && slave_posted_write_ack_trim &&
       slv_cnt_reg >= T28_TRIM_CYC) |=> !SLV_DTACK_OE_N_OUT;
  endproperty
  a_slave_posted: assert property (p_slave_posted) else $error("posted ack late");
  property p_slave_prefetch;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (ds_active && SLV_ACK_REQ_IN && SLV_PREFETCH_RD_IN && slave_prefetch_read_ack_trim &&
       slv_cnt_reg >= T28_TRIM_CYC) |=> !SLV_DTACK_OE_N_OUT;
  endproperty
  a_slave_prefetch: assert property (p_slave_prefetch) else $error("prefetch ack late");
  property p_cfg_write;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      cfg_write |=> timing_trim_config_reg == $past(PWDATA_IN[CFG_WIDTH-1:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");
  property p_reset_cfg;
    @(posedge CLOCK_IN) RST_IN |=> timing_trim_config_reg == CFG_RESET;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("config not compliant after reset");
endmodule

// ### sim/bus_far_side.sv
// far-side bus model: remote slave answering us, remote master strobing us
`timescale 1ns/1ps
module bus_far_side (
  input wire logic clk_in,
  input wire logic our_ds0_n_in,
  input wire logic our_dtack_oe_n_in,
  input wire logic strobe_cmd_in,
  output logic dtack_n_out,
  output logic ds0_n_out,
  output logic ds1_n_out
);
  logic ack_pull_reg;
  // =====================================================
  // remote slave: acknowledges a cycle late, lets go a cycle after our strobe rises
  always_ff @(posedge clk_in) begin
    ack_pull_reg <= ~our_ds0_n_in;
  end
  // =====================================================
  // open-drain lines with pull-ups, so a released line reads high
  assign dtack_n_out = ~ack_pull_reg & our_dtack_oe_n_in;
  assign ds0_n_out = our_ds0_n_in & ~strobe_cmd_in;
  assign ds1_n_out = ~strobe_cmd_in;
endmodule

// ### sim/tb_top.sv
// self-checking bench for the bus timing trim block
`timescale 1ns/1ps
module tb_top;
  import trim_pkg::*;
  logic CLOCK_IN = 0, RST_IN = 1, PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0;
  logic [11:0] PADDR_IN = 12'h000;
  logic [31:0] PWDATA_IN = 32'h0, PRDATA_OUT, q;
  logic PREADY_OUT, PSLVERR_OUT, DTACK_N_IN, DS0_N_IN, DS1_N_IN, e;
  logic DS0_N_OUT, MST_TERMINATE_OUT, SLV_DTACK_OE_N_OUT, strobe_cmd = 0;
  logic MST_REQ_IN = 0, MST_READ_IN = 0, SLV_ACK_REQ_IN = 0;
  logic SLV_POSTED_WR_IN = 0, SLV_PREFETCH_RD_IN = 0;
  int fails = 0, check_count = 0, cycles = 0;
  int lat[4], gap[2], sl[4], lw, lr, g;

  vme_timing_trim_control uut (.CLOCK_IN, .RST_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN,
    .PADDR_IN, .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .DTACK_N_IN,
    .DS0_N_IN, .DS1_N_IN, .MST_REQ_IN, .MST_READ_IN, .DS0_N_OUT, .MST_TERMINATE_OUT,
    .SLV_ACK_REQ_IN, .SLV_POSTED_WR_IN, .SLV_PREFETCH_RD_IN, .SLV_DTACK_OE_N_OUT);

  bus_far_side far (.clk_in(CLOCK_IN), .our_ds0_n_in(DS0_N_OUT),
    .our_dtack_oe_n_in(SLV_DTACK_OE_N_OUT), .strobe_cmd_in(strobe_cmd),
    .dtack_n_out(DTACK_N_IN), .ds0_n_out(DS0_N_IN), .ds1_n_out(DS1_N_IN));

  initial begin
    forever #10 CLOCK_IN = ~CLOCK_IN;
  end

  // =====================================================
  // reporting
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // hang guard, the whole run needs a few hundred cycles
  always @(posedge CLOCK_IN) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end

  // =====================================================
  // bus and pin tasks
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLOCK_IN);
    PSEL_IN <= 1'b1;
    PENABLE_IN <= 1'b0;
    PWRITE_IN <= wr;
    PADDR_IN <= a;
    PWDATA_IN <= d;
    @(posedge CLOCK_IN);
    PENABLE_IN <= 1'b1;
    // no limit of its own: if PREADY_OUT never rises, only the hang guard ends this wait
    do begin
      @(posedge CLOCK_IN);
    end while (PREADY_OUT !== 1'b1);
    q = PRDATA_OUT;
    e = PSLVERR_OUT;
    PSEL_IN <= 1'b0;
    PENABLE_IN <= 1'b0;
  endtask

  function automatic logic hit(input int w);
    case (w)
      0: return DS0_N_OUT === 1'b0;
      1: return MST_TERMINATE_OUT === 1'b1;
      default: return SLV_DTACK_OE_N_OUT === 1'b0;
    endcase
  endfunction

  // outputs looked at 1 ns after the edge, once its updates have landed
  task automatic wait_for(input int w, output int n);
    n = 0;
    do begin
      @(posedge CLOCK_IN);
      #1;
      n++;
    end while (!hit(w) && n < 300);
    if (n >= 300) chk(32'h0, 32'h1);
  endtask

  // two master cycles; gap is how soon the second one strobes again
  task automatic mst(input logic rd, output int lt, output int gp);
    int n;
    @(posedge CLOCK_IN);
    MST_REQ_IN <= 1'b1;
    MST_READ_IN <= rd;
    wait_for(0, n);
    wait_for(1, lt);
    @(posedge CLOCK_IN);
    MST_REQ_IN <= 1'b0;
    @(posedge CLOCK_IN);
    MST_REQ_IN <= 1'b1;
    wait_for(0, gp);
    wait_for(1, n);
    @(posedge CLOCK_IN);
    MST_REQ_IN <= 1'b0;
    repeat (12) @(posedge CLOCK_IN);
  endtask

  task automatic slv(input logic pw, input logic pf, output int n);
    @(posedge CLOCK_IN);
    SLV_POSTED_WR_IN <= pw;
    SLV_PREFETCH_RD_IN <= pf;
    SLV_ACK_REQ_IN <= 1'b1;
    strobe_cmd <= 1'b1;
    wait_for(2, n);
    @(posedge CLOCK_IN);
    strobe_cmd <= 1'b0;
    SLV_ACK_REQ_IN <= 1'b0;
    repeat (12) @(posedge CLOCK_IN);
  endtask

  // =====================================================
  // tests
  initial begin
    repeat (3) @(posedge CLOCK_IN);
    RST_IN <= 1'b0;
    apb(0, TRIM_CFG_ADDR, 32'h0);
    chk(q, 32'h0);
    apb(0, TRIM_STATUS_ADDR, 32'h0);
    chk(q, 32'h0000000f);
    apb(1, 12'h400, 32'hffffffff);
    chk(e, 32'h1);
    apb(0, 12'h400, 32'h0);
    chk({q[30:0], e}, 32'h1);
    apb(0, TRIM_CFG_ADDR, 32'h0);
    chk(q, 32'h0);
    apb(1, TRIM_CFG_ADDR, 32'hffffffff);
    apb(0, TRIM_CFG_ADDR, 32'h0);
    chk({q[30:0], e}, 32'h7e);
    $display("test registers done");
    // trims set only where the board delays make up for them
    for (int i = 0; i < 4; i++) begin
      apb(1, TRIM_CFG_ADDR, 32'(i << RD_TERM_LSB));
      mst(1, lat[i], g);
    end
    chk(lat[0] - lat[2], 32'(T27_CYC));
    chk(lat[1] - lat[2], 32'(T27_SHORT_CYC));
    chk(lat[3], lat[0]);
    apb(1, TRIM_CFG_ADDR, 32'h0);
    mst(0, lw, gap[0]);
    chk(lw, lat[2]);
    chk(gap[0], 32'(T11_CYC + 4));
    apb(1, TRIM_CFG_ADDR, 32'h2);
    mst(0, lw, gap[1]);
    chk(gap[0] - gap[1], 32'h1);
    chk(gap[1], 32'(T11_TRIM_CYC + 4));
    apb(1, TRIM_CFG_ADDR, 32'h9);
    mst(1, lr, g);
    chk(32'(lr < lat[2]), 32'h1);
    chk(32'(lat[2] >= ACK_FULL_SAMPLES + 2), 32'h1);
    $display("test master done");
    apb(1, TRIM_CFG_ADDR, 32'h0);
    slv(1, 0, sl[0]);
    apb(1, TRIM_CFG_ADDR, 32'h30);
    slv(0, 0, sl[1]);
    slv(1, 0, sl[2]);
    slv(0, 1, sl[3]);
    chk(sl[1], sl[0]);
    chk(32'(sl[0] >= T28_CYC + 3), 32'h1);
    chk(sl[0] - sl[2], 32'h1);
    chk(sl[0] - sl[3], 32'h1);
    $display("test slave done");
    @(posedge CLOCK_IN);
    RST_IN <= 1'b1;
    repeat (2) @(posedge CLOCK_IN);
    RST_IN <= 1'b0;
    apb(0, TRIM_CFG_ADDR, 32'h0);
    chk(q, 32'h0);
    $display("test second reset done");
    wrap_up();
  end
endmodule
